// ===== shared/lqc_pkg.sv
// Package: constants for the latency and quad configuration register bank and its serial link
package lqc_pkg;
  // Configuration register addresses on the any-register commands
  localparam logic [23:0] ADDR_CFG_NV   = 24'h000002;
  localparam logic [23:0] ADDR_CFG_V    = 24'h070002;
  // Opcodes; only the write-any-register value is fixed, others are plain defaults
  localparam logic [7:0]  OP_WREN       = 8'h06;
  localparam logic [7:0]  OP_WR_ANY     = 8'h71;
  localparam logic [7:0]  OP_RD_ANY     = 8'h65;
  localparam logic [7:0]  OP_RDCFG1     = 8'h35;
  localparam logic [7:0]  OP_FAST_READ  = 8'h0b;
  // Field layout of the configuration byte
  localparam int          LAT_MSB       = 7;
  localparam int          LAT_LSB       = 4;
  localparam int          QUAD_BIT      = 1;
  localparam logic [7:0]  CFG_WMASK     = 8'hf2;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  // Idle levels of the synchronised device pins: sclk, cs_n, mosi, hw_reset_n
  localparam logic [3:0]  PIN_IDLE      = 4'h5;
  // Mode byte length in clock cycles per lane layout
  localparam logic [4:0]  MODE_CYC_1    = 5'h08;
  localparam logic [4:0]  MODE_CYC_2    = 5'h04;
  localparam logic [4:0]  MODE_CYC_4    = 5'h02;
  localparam logic [4:0]  MODE_CYC_DDR  = 5'h01;
  // Serial clock timing
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          SCLK_HALF_NS  = 200;
  localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Controller register offsets
  localparam logic [3:0]  HREG_CTRL     = 4'h0;
  localparam logic [3:0]  HREG_ADDR     = 4'h4;
  localparam logic [3:0]  HREG_WDATA    = 4'h8;
  localparam logic [3:0]  HREG_RXDATA   = 4'hc;
  // Lane layout (command, address, data)
  typedef enum logic [1:0] {
    FMT_SINGLE,
    FMT_DUAL_ALL,
    FMT_QUAD_DATA,
    FMT_QUAD_ALL
  } lqc_fmt_t;
endpackage : lqc_pkg

// ===== shared/lqc_link.sv
// Interface: serial link between controller and configuration register bank
interface lqc_link;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport host (output sclk, output cs_n, output mosi, input miso);
  modport device (input sclk, input cs_n, input mosi, output miso);
endinterface : lqc_link

// ===== src/lqc_sync.sv
// Two-flop synchroniser for pin inputs
module lqc_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : lqc_sync

// ===== src/lqc_device.sv
// Device end: latency and quad configuration registers behind the serial link
module lqc_device
  import lqc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       hw_reset_n,
  input  wire logic       four_lane_protocol_mode,
  input  wire logic       two_lane_protocol_mode,
  input  wire logic       double_rate,
  input  wire logic [7:0] mem_rdata,
  lqc_link.device         link,
  output logic      [3:0] read_latency_code,
  output logic            quad_enable,
  output logic            write_enable_latch,
  output lqc_fmt_t        lane_fmt,
  output logic     [23:0] mem_addr
);
  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_WDATA,
    ST_WAIT,
    ST_DATA,
    ST_IGNORE
  } lqc_dev_state_t;

  lqc_dev_state_t state;
  logic [3:0]     pins;
  logic           s_sclk;
  logic           s_cs_n;
  logic           s_mosi;
  logic           s_hwrst_n;
  logic           sclk_d;
  logic           cs_d;
  logic [4:0]     bitcnt;
  logic [4:0]     wait_cnt;
  logic [7:0]     opcode;
  logic [7:0]     shin;
  logic [23:0]    addr;
  logic [7:0]     out_shift;
  logic [7:0]     cfg_nv;
  logic [7:0]     cfg_v;
  logic           miso;

  // Link pins and hardware reset cross into clk_sys before anything looks at them
  // Reset value equals the idle pins, so no false edge or hardware reset follows reset
  lqc_sync #(.W(4), .INIT(PIN_IDLE)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     ({link.sclk, link.cs_n, link.mosi, hw_reset_n}),
    .dout    (pins)
  );
  assign {s_sclk, s_cs_n, s_mosi, s_hwrst_n} = pins;

  // Edge detection on the synchronised serial clock and select
  wire sel       = ~s_cs_n;
  wire rise      = sel & s_sclk & ~sclk_d;
  wire fall      = sel & ~s_sclk & sclk_d;
  wire cs_rise   = s_cs_n & ~cs_d;
  wire hw_rst    = ~s_hwrst_n;
  wire last_bit8 = (bitcnt == 5'd7);
  wire last_adr  = (bitcnt == 5'd23);
  wire [7:0]  next_shin = {shin[6:0], s_mosi};
  wire [23:0] next_addr = {addr[22:0], s_mosi};

  // Register decode; both addresses read the volatile copy
  wire        hit_nv    = (addr == ADDR_CFG_NV);
  wire        hit_v     = (addr == ADDR_CFG_V);
  wire        rd_hit    = (next_addr == ADDR_CFG_NV) || (next_addr == ADDR_CFG_V);
  wire [7:0]  cfg_rd    = cfg_v & CFG_WMASK;
  wire [7:0]  read_any_register_cmd_byte = rd_hit ? cfg_rd : 8'h00;
  wire        wr_ok     = rise && (state == ST_WDATA) && last_bit8 && write_enable_latch
                          && !hw_rst;
  wire        wr_nv     = wr_ok && hit_nv;
  wire        wr_v      = wr_ok && hit_v;
  wire [7:0]  cfg_wdata = next_shin & CFG_WMASK;

  // Mode byte length is one cycle at double rate, else follows the active lane layout; latency adds on top
  wire [4:0] mode_cyc =
    double_rate                ? MODE_CYC_DDR :
    (lane_fmt == FMT_QUAD_ALL) ? MODE_CYC_4 :
    (lane_fmt == FMT_DUAL_ALL) ? MODE_CYC_2 : MODE_CYC_1;
  wire [4:0] wait_total = mode_cyc + {1'b0, read_latency_code};

  // Settings are taken only from the volatile copy
  assign read_latency_code = cfg_v[LAT_MSB:LAT_LSB];
  assign quad_enable       = cfg_v[QUAD_BIT];
  assign lane_fmt =
    four_lane_protocol_mode ? FMT_QUAD_ALL :
    two_lane_protocol_mode  ? FMT_DUAL_ALL :
    quad_enable             ? FMT_QUAD_DATA : FMT_SINGLE;
  assign link.miso = miso;

  // Edge history for the synchronised pins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      sclk_d <= s_sclk;
      cs_d   <= s_cs_n;
    end
  end

  // Non-volatile copy only survives hardware reset; nrst stands for power-up
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_nv <= CFG_RESET;
    end else if (wr_nv) begin
      cfg_nv <= cfg_wdata;
    end
  end

  // Volatile copy: reload on hardware reset, else take register writes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_v <= CFG_RESET;
    end else if (hw_rst) begin
      cfg_v <= cfg_nv;
    end else if (wr_nv || wr_v) begin
      cfg_v <= cfg_wdata;
    end
  end

  // Write enable latch: set after enable command, cleared after register write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      write_enable_latch <= 1'b0;
    end else if (hw_rst) begin
      write_enable_latch <= 1'b0;
    end else if (cs_rise && opcode == OP_WREN && state == ST_IGNORE) begin
      write_enable_latch <= 1'b1;
    end else if (cs_rise && opcode == OP_WR_ANY) begin
      write_enable_latch <= 1'b0;
    end
  end

  // Frame sequencer: samples on rising edges, shifts out on falling edges
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_CMD;
      bitcnt    <= 5'd0;
      wait_cnt  <= 5'd0;
      opcode    <= 8'h00;
      shin      <= 8'h00;
      addr      <= 24'h0;
      out_shift <= 8'h00;
      miso      <= 1'b0;
      mem_addr  <= 24'h0;
    end else if (hw_rst || !sel) begin
      // Deselect ends the frame; opcode kept one cycle for the latch
      state  <= ST_CMD;
      bitcnt <= 5'd0;
      if (!cs_rise) begin
        opcode <= 8'h00;
      end
    end else if (rise) begin
      unique case (state)
        ST_CMD: begin
          shin   <= next_shin;
          bitcnt <= bitcnt + 5'd1;
          if (last_bit8) begin
            opcode <= next_shin;
            bitcnt <= 5'd0;
            if (next_shin == OP_WR_ANY || next_shin == OP_RD_ANY
                || next_shin == OP_FAST_READ) begin
              state <= ST_ADDR;
            end else if (next_shin == OP_RDCFG1) begin
              state     <= ST_DATA;
              out_shift <= cfg_rd;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          addr   <= next_addr;
          bitcnt <= bitcnt + 5'd1;
          if (last_adr) begin
            bitcnt <= 5'd0;
            if (opcode == OP_WR_ANY) begin
              state <= ST_WDATA;
            end else if (opcode == OP_RD_ANY) begin
              state     <= ST_DATA;
              out_shift <= read_any_register_cmd_byte;
            end else begin
              state    <= ST_WAIT;
              wait_cnt <= wait_total;
              mem_addr <= next_addr;
            end
          end
        end
        ST_WDATA: begin
          shin   <= next_shin;
          bitcnt <= bitcnt + 5'd1;
          if (last_bit8) begin
            state <= ST_IGNORE;
          end
        end
        ST_WAIT: begin
          // One rising edge per dummy cycle, whatever the data rate
          wait_cnt <= wait_cnt - 5'd1;
          if (wait_cnt == 5'd1) begin
            state     <= ST_DATA;
            out_shift <= mem_rdata;
            mem_addr  <= mem_addr + 24'd1;
          end
        end
        ST_DATA, ST_IGNORE: begin
        end
      endcase
    end else if (fall && state == ST_DATA) begin
      miso      <= out_shift[7];
      out_shift <= {out_shift[6:0], 1'b0};
      bitcnt    <= bitcnt + 5'd1;
      if (last_bit8) begin
        // Register reads repeat the byte; memory reads stream onward
        bitcnt <= 5'd0;
        if (opcode == OP_FAST_READ) begin
          out_shift <= mem_rdata;
          mem_addr  <= mem_addr + 24'd1;
        end else if (opcode == OP_RD_ANY) begin
          out_shift <= (hit_nv || hit_v) ? cfg_rd : 8'h00;
        end else begin
          out_shift <= cfg_rd;
        end
      end
    end
  end
endmodule : lqc_device

// ===== src/lqc_host.sv
// Host end: register-driven controller issuing frames on the serial link
module lqc_host
  import lqc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  lqc_link.host            link
);
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_RUN,
    HS_TAIL,
    HS_GAP
  } lqc_host_state_t;

  lqc_host_state_t state;
  logic [23:0] addr;
  logic [7:0]  wdata;
  logic [3:0]  dummy;
  logic [47:0] tx;
  logic [7:0]  rx;
  logic [7:0]  rxdata;
  logic [6:0]  bitidx;
  logic [6:0]  nskip;
  logic [6:0]  total;
  logic [3:0]  timer;
  logic        sclk;
  logic        cs_n;
  logic        miso_s;

  lqc_sync #(.W(1)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (link.miso),
    .dout    (miso_s)
  );

  // Frame shape per opcode: bits out, dummy wait, bits in
  wire [7:0] op       = reg_wdata[7:0];
  wire       is_fast  = (op == OP_FAST_READ);
  wire       is_read  = is_fast || op == OP_RD_ANY || op == OP_RDCFG1;
  wire [6:0] n_out    = (op == OP_WR_ANY || is_fast) ? 7'd40 :
                        (op == OP_RD_ANY)            ? 7'd32 : 7'd8;
  wire [6:0] n_wait   = is_fast ? {3'b000, dummy} : 7'd0;
  wire [6:0] n_in     = is_read ? 7'd8 : 7'd0;
  wire [7:0] tail_byt = is_fast ? 8'h00 : wdata; // Mode byte 00 keeps continuous read off
  wire       busy     = (state != HS_IDLE);
  wire       go       = reg_wr && reg_addr == HREG_CTRL && !busy;
  wire       tick     = (timer == 4'(SCLK_HALF_CYC - 1));

  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.mosi = tx[47];

  // Register writes for address, data and latency
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr  <= 24'h0;
      wdata <= 8'h00;
      dummy <= 4'h0;
    end else if (reg_wr && reg_addr == HREG_ADDR) begin
      addr <= reg_wdata[23:0];
    end else if (reg_wr && reg_addr == HREG_WDATA) begin
      wdata <= reg_wdata[7:0];
      dummy <= reg_wdata[11:8];
    end
  end

  // Read data stands in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        HREG_CTRL:   reg_rdata <= {31'h0, busy};
        HREG_ADDR:   reg_rdata <= {8'h00, addr};
        HREG_WDATA:  reg_rdata <= {20'h0, dummy, wdata};
        HREG_RXDATA: reg_rdata <= {24'h0, rxdata};
        default:     reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // Frame engine: clock divided from clk_sys, sample at end of high phase
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state  <= HS_IDLE;
      sclk   <= 1'b0;
      cs_n   <= 1'b1;
      tx     <= 48'h0;
      rx     <= 8'h00;
      rxdata <= 8'h00;
      bitidx <= 7'd0;
      nskip  <= 7'd0;
      total  <= 7'd0;
      timer  <= 4'd0;
    end else begin
      timer <= tick ? 4'd0 : timer + 4'd1;
      unique case (state)
        HS_IDLE: begin
          timer <= 4'd0;
          if (go) begin
            state  <= HS_RUN;
            cs_n   <= 1'b0;
            tx     <= {op, addr, tail_byt, 8'h00};
            bitidx <= 7'd0;
            nskip  <= n_out + n_wait;
            total  <= n_out + n_wait + n_in;
          end
        end
        HS_RUN: begin
          if (tick) begin
            sclk <= ~sclk;
            if (sclk) begin
              // Full clock period per bit, dummy cycles included
              if (bitidx >= nskip) begin
                rx <= {rx[6:0], miso_s};
              end
              tx     <= {tx[46:0], 1'b0};
              bitidx <= bitidx + 7'd1;
              if (bitidx == total - 7'd1) begin
                state <= HS_TAIL;
              end
            end
          end
        end
        HS_TAIL: begin
          if (tick) begin
            cs_n   <= 1'b1;
            rxdata <= rx;
            state  <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (tick) begin
            state <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule : lqc_host

// ===== verif/lqc_link_sva.sv
// Checker: timing relations on the serial link between host and device ends
module lqc_link_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Clock idles low between frames so the device never sees a stray edge
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_high_half_full: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  a_low_half_full: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  a_next_rise_bound: assert property ($fell(sclk) |-> ##[4:12] (sclk || cs_n))
    else $error("serial clock stalled inside a frame");
  // Data may only move while the clock is low, never across a sampling edge
  a_mosi_held_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_miso_held_high: assert property (!cs_n && sclk && $past(sclk) |-> $stable(miso))
    else $error("device data moved while clock high");
  a_frame_start_low: assert property ($fell(cs_n) |-> !sclk [*4])
    else $error("frame started without a low setup phase");
  a_frame_gap_min: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("select high gap shorter than four cycles");
endmodule : lqc_link_sva

// ===== verif/test_config_latency_registers.sv
// Testbench: host and device ends joined on one link, driven through the host port
module test_config_latency_registers
  import lqc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys    = 1'b0;
  logic        nrst       = 1'b0;
  logic        hw_reset_n = 1'b1;
  logic        four_lane  = 1'b0;
  logic        two_lane   = 1'b0;
  logic        double_rate = 1'b0;
  logic [3:0]  reg_addr   = 4'h0;
  logic [31:0] reg_wdata  = 32'h0;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  mem_rdata;
  logic [3:0]  read_latency_code;
  logic        quad_enable;
  logic        write_enable_latch;
  lqc_fmt_t    lane_fmt;
  logic [23:0] mem_addr;
  int          err_total  = 0;
  int          samples_checked = 0;
  logic [7:0]  nv, vol, b;
  logic [31:0] d;

  always #25 clk_sys = ~clk_sys;

  // Expected register image: reserved bits never stick
  function automatic logic [7:0] cfg_image(input logic [7:0] w);
    return w & CFG_WMASK;
  endfunction : cfg_image

  // Memory model: a fixed pattern of the read pointer
  function automatic logic [7:0] mem_byte(input logic [23:0] ad);
    return ad[7:0] ^ 8'ha5;
  endfunction : mem_byte

  assign mem_rdata = mem_byte(mem_addr);

  lqc_link link ();

  lqc_host lqc_host_inst (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link)
  );

  lqc_device lqc_device_inst (
    .clk_sys(clk_sys), .nrst(nrst), .hw_reset_n(hw_reset_n),
    .four_lane_protocol_mode(four_lane), .two_lane_protocol_mode(two_lane),
    .double_rate(double_rate), .mem_rdata(mem_rdata), .link(link),
    .read_latency_code(read_latency_code), .quad_enable(quad_enable),
    .write_enable_latch(write_enable_latch), .lane_fmt(lane_fmt), .mem_addr(mem_addr)
  );

  lqc_link_sva lqc_link_sva_inst (
    .clk_sys(clk_sys), .nrst(nrst), .sclk(link.sclk), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso(link.miso)
  );

  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle strobes, launched just after a rising edge
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge clk_sys);
    reg_addr  <= ad;
    reg_wdata <= dt;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] ad, output logic [31:0] dt);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    dt = reg_rdata;
  endtask : rd

  // Start a frame, poll busy under a bound, return the last received byte
  task automatic frame(input logic [7:0] op, output logic [31:0] rx);
    int          n;
    logic [31:0] s;
    wr(HREG_CTRL, {24'h0, op});
    s = 32'h1;
    for (n = 0; n < 1000 && s[0] !== 1'b0; n++) begin
      rd(HREG_CTRL, s);
    end
    if (s[0] !== 1'b0) begin
      check(s, 32'h0);
      conclude();
    end
    rd(HREG_RXDATA, rx);
  endtask : frame

  task automatic cfg_write(input logic [23:0] ad, input logic [7:0] dt, input logic wen);
    wr(HREG_ADDR, {8'h0, ad});
    wr(HREG_WDATA, {24'h0, dt});
    if (wen) begin
      frame(OP_WREN, d);
      check(write_enable_latch, 1'b1);
    end
    frame(OP_WR_ANY, d);
    check(write_enable_latch, 1'b0);
  endtask : cfg_write

  // Outputs and every register read path must show the volatile copy; an unmapped address reads zero
  task automatic expect_cfg();
    logic [23:0] ra [3];
    ra = '{ADDR_CFG_NV, ADDR_CFG_V, 24'h000004};
    check(read_latency_code, vol[7:4]);
    check(quad_enable, vol[1]);
    check(lane_fmt, vol[1] ? FMT_QUAD_DATA : FMT_SINGLE);
    frame(OP_RDCFG1, d);
    check(d, {24'h0, vol});
    for (int i = 0; i < 3; i++) begin
      wr(HREG_ADDR, {8'h0, ra[i]});
      frame(OP_RD_ANY, d);
      check(d, (i < 2) ? {24'h0, vol} : 32'h0);
    end
  endtask : expect_cfg

  initial begin
    logic [3:0]  c;
    logic [23:0] a;
    logic        k;
    void'($urandom(32'hd27ee5c2));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    nv  = 8'h00;
    vol = 8'h00;
    rd(4'h2, d);
    check(d, 32'h0);
    check(write_enable_latch, 1'b0);
    expect_cfg();
    // Write without the latch set must leave the register alone
    cfg_write(ADDR_CFG_V, 8'hf0, 1'b0);
    expect_cfg();
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? 8'hff : 8'($urandom);
      k = (i == 0) ? 1'b0 : 1'($urandom_range(0, 1));
      cfg_write(k ? ADDR_CFG_V : ADDR_CFG_NV, b, 1'b1);
      vol = cfg_image(b);
      if (!k) nv = vol;
      expect_cfg();
    end
    // Volatile differs from non-volatile, then the hardware reset reloads it
    cfg_write(ADDR_CFG_V, ~nv, 1'b1);
    vol = cfg_image(~nv);
    expect_cfg();
    @(posedge clk_sys);
    hw_reset_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    hw_reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    vol = nv;
    expect_cfg();
    // Reads with the latency code at both ends of its range
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
      a = 24'($urandom);
      cfg_write(ADDR_CFG_V, {c, 4'h0}, 1'b1);
      check(read_latency_code, c);
      wr(HREG_ADDR, {8'h0, a});
      wr(HREG_WDATA, {20'h0, c, 8'h0});
      frame(OP_FAST_READ, d);
      check(d, {24'h0, mem_byte(a)});
    end
    // Double rate takes the mode byte as one cycle, so the host trims its wait by seven
    c = 4'(7 + $urandom_range(0, 8));
    a = 24'($urandom);
    cfg_write(ADDR_CFG_V, {c, 4'h0}, 1'b1);
    @(posedge clk_sys);
    double_rate <= 1'b1;
    wr(HREG_ADDR, {8'h0, a});
    wr(HREG_WDATA, {20'h0, c - 4'd7, 8'h0});
    frame(OP_FAST_READ, d);
    check(d, {24'h0, mem_byte(a)});
    @(posedge clk_sys);
    double_rate <= 1'b0;
    // Lane layout follows the protocol mode pins, four-lane winning
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      four_lane <= i[1];
      two_lane  <= i[0];
      @(negedge clk_sys);
      check(lane_fmt, i[1] ? FMT_QUAD_ALL : i[0] ? FMT_DUAL_ALL : FMT_SINGLE);
    end
    @(posedge clk_sys);
    four_lane <= 1'b0;
    two_lane  <= 1'b0;
    nrst      <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    nv  = 8'h00;
    vol = 8'h00;
    expect_cfg();
    conclude();
  end
endmodule : test_config_latency_registers
